// >>> rtl/uecr_top.sv
// Endpoint 0 control/status and USB clock/reset control registers behind AXI4-Lite.
// Assumes engine events arrive on clk as one-cycle pulses and PHY pins are asynchronous.
`include "uecr_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module uecr_top
    import uecr_pkg::*;
#(
    parameter int ADDR_W = `UECR_ADDR_W
)
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire uecr_ep0_evt_type  ep0_evt,
    output uecr_ep0_ctl_type       ep0_ctl,
    input  wire uecr_bus_evt_type  bus_evt,
    input  wire uecr_phy_pins_type phy_pins,
    output uecr_otg_mon_type       otg_mon,
    output logic                   irq_request
);

    // Write and read channel holding registers.
    logic [ADDR_W-1:0] aw_addr_r;
    logic              aw_held_r;
    logic [31:0]       w_data_r;
    logic [3:0]        w_strb_r;
    logic              w_held_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              rvalid_r;
    logic [1:0]        rresp_r;
    logic [31:0]       rdata_r;

    // Endpoint 0 state.
    logic ping_r;
    logic toggle_wren_r;
    logic toggle_r;
    logic flush_r;
    logic svc_setend_r;
    logic svc_rx_r;
    logic setup_end_r;
    logic nak_halt_r;
    logic stat_req_r;
    logic in_req_r;
    logic tx_ready_r;
    logic rx_ready_r;

    // Clock/reset control state.
    logic                  gen_flag_r;
    logic                  resume_flag_r;
    logic                  act_flag_r;
    logic [`UECR_CTL_W-1:0] ctl_r;

    // Pin synchronisers.
    logic [4:0] pin_s1_r;
    logic [4:0] pin_s2_r;
    logic [4:0] pin_s3_r;
    logic [4:0] pin_f_r;

    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        addr_is = (a == ofs);
    endfunction : addr_is

    // Bus decode.
    wire logic        do_write  = aw_held_r && w_held_r && !bvalid_r;
    wire logic        wr_csr    = do_write && addr_is(aw_addr_r, `UECR_OFS_EP0_CSR);
    wire logic        wr_crc    = do_write && addr_is(aw_addr_r, `UECR_OFS_CLK_RST);
    wire logic        wr_bad    = do_write && !wr_csr && !wr_crc;
    wire logic        rd_take   = s_axi_arvalid && !rvalid_r;
    wire logic        rd_csr    = addr_is(s_axi_araddr, `UECR_OFS_EP0_CSR);
    wire logic        rd_crc    = addr_is(s_axi_araddr, `UECR_OFS_CLK_RST);
    wire logic [31:0] wmask     = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                                   {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    wire logic [31:0] csr_wen   = wr_csr ? wmask : 32'h0000_0000;
    wire logic [31:0] crc_wen   = wr_crc ? wmask : 32'h0000_0000;
    wire logic [31:0] csr_one   = csr_wen & w_data_r;
    wire logic        host      = ep0_evt.host_role;

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;

    // Endpoint 0 next values.
    wire logic ping_nxt     = csr_wen[`UECR_B_PING_SUPPRESS] ?
                              w_data_r[`UECR_B_PING_SUPPRESS] : ping_r;
    wire logic twe_nxt      = host && csr_one[`UECR_B_TOGGLE_WREN];
    wire logic toggle_wr    = host && csr_wen[`UECR_B_TOGGLE_STATE]
                              && (csr_one[`UECR_B_TOGGLE_WREN] || toggle_wren_r);
    wire logic toggle_nxt   = ep0_evt.toggle_load ? ep0_evt.toggle_value :
                              toggle_wr ? w_data_r[`UECR_B_TOGGLE_STATE] : toggle_r;
    wire logic flush_nxt    = csr_one[`UECR_B_FLUSH] || (flush_r && !ep0_evt.flush_done);
    wire logic flush_tx     = flush_r && ep0_evt.flush_done && tx_ready_r;
    wire logic flush_rx     = flush_r && ep0_evt.flush_done && !tx_ready_r;
    wire logic svc_set_nxt  = !host && csr_one[`UECR_B_SVC_SETEND];
    wire logic setup_nxt    = ep0_evt.setup_end_event || (setup_end_r && !svc_set_nxt);
    wire logic nak_clr      = host && csr_wen[`UECR_B_SVC_SETEND]
                              && !w_data_r[`UECR_B_SVC_SETEND];
    wire logic nak_nxt      = (host && ep0_evt.nak_timeout_event) || (nak_halt_r && !nak_clr);
    wire logic svc_rx_nxt   = !host && csr_one[`UECR_B_SVC_RX];
    wire logic rx_nxt       = ep0_evt.rx_packet_in
                              || (rx_ready_r && !svc_rx_nxt && !flush_rx);
    wire logic stat_wr      = host && csr_wen[`UECR_B_SVC_RX];
    wire logic stat_nxt     = stat_wr ? w_data_r[`UECR_B_SVC_RX] :
                              (stat_req_r && !ep0_evt.tx_sent && !ep0_evt.in_done);
    wire logic req_wr       = host && csr_wen[`UECR_B_REQ_PKT];
    wire logic req_nxt      = req_wr ? w_data_r[`UECR_B_REQ_PKT] :
                              (in_req_r && !ep0_evt.in_done);
    wire logic tx_nxt       = csr_one[`UECR_B_TX_READY]
                              || (tx_ready_r && !ep0_evt.tx_sent && !flush_tx);

    // Clock/reset control next values.
    wire logic gen_nxt      = bus_evt.bus_event || (gen_flag_r && !bus_evt.bus_event_clear);
    wire logic resume_nxt   = bus_evt.suspended
                              && (resume_flag_r || bus_evt.resume_detect);
    wire logic act_wr_val   = crc_wen[`UECR_B_ACT_FLAG] ? w_data_r[`UECR_B_ACT_FLAG] : act_flag_r;
    wire logic act_nxt      = bus_evt.activity || act_wr_val;
    wire logic [`UECR_CTL_W-1:0] ctl_nxt = (ctl_r & ~crc_wen[`UECR_CTL_W-1:0])
                              | (w_data_r[`UECR_CTL_W-1:0] & crc_wen[`UECR_CTL_W-1:0]);

    // Read-back images; bits not listed read zero.
    wire logic [31:0] csr_img = {4'h0,
                                 ping_r, toggle_wren_r, toggle_r, flush_r,
                                 host ? nak_halt_r : svc_setend_r,
                                 host ? stat_req_r : svc_rx_r,
                                 host ? in_req_r : 1'b0,
                                 host ? 1'b0 : setup_end_r,
                                 2'h0, tx_ready_r, rx_ready_r,
                                 16'h0000};
    wire logic [31:0] crc_img = {5'h00, gen_flag_r, resume_flag_r, act_flag_r,
                                 8'h00, 1'b1, 5'h00, ctl_r};
    wire logic [31:0] rd_img  = rd_csr ? csr_img : rd_crc ? crc_img : 32'h0000_0000;

    // Write channel: address and data are taken in either order.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
            w_held_r  <= 1'b0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            else if (do_write)
                aw_held_r <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            else if (do_write)
                w_held_r <= 1'b0;
        end
    end

    // Write response; an unmapped address answers with a slave error.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bvalid_r <= 1'b0;
            bresp_r  <= `UECR_RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_bad ? `UECR_RESP_SLVERR : `UECR_RESP_OKAY;
        end
        else if (s_axi_bready)
            bvalid_r <= 1'b0;
    end

    // Read channel: data is the register image at the edge the address is taken.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rvalid_r <= 1'b0;
            rresp_r  <= `UECR_RESP_OKAY;
            rdata_r  <= 32'h0000_0000;
        end
        else if (rd_take)
        begin
            rvalid_r <= 1'b1;
            rresp_r  <= (rd_csr || rd_crc) ? `UECR_RESP_OKAY : `UECR_RESP_SLVERR;
            rdata_r  <= rd_img;
        end
        else if (s_axi_rready)
            rvalid_r <= 1'b0;
    end

    // Endpoint 0 registers; hardware sets win over software clears.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ping_r        <= 1'b0;
            toggle_wren_r <= 1'b0;
            toggle_r      <= 1'b0;
            flush_r       <= 1'b0;
            svc_setend_r  <= 1'b0;
            svc_rx_r      <= 1'b0;
            setup_end_r   <= 1'b0;
            nak_halt_r    <= 1'b0;
            stat_req_r    <= 1'b0;
            in_req_r      <= 1'b0;
            tx_ready_r    <= 1'b0;
            rx_ready_r    <= 1'b0;
        end
        else
        begin
            ping_r        <= ping_nxt;
            toggle_wren_r <= twe_nxt;
            toggle_r      <= toggle_nxt;
            flush_r       <= flush_nxt;
            svc_setend_r  <= svc_set_nxt;
            svc_rx_r      <= svc_rx_nxt;
            setup_end_r   <= setup_nxt;
            nak_halt_r    <= nak_nxt;
            stat_req_r    <= stat_nxt;
            in_req_r      <= req_nxt;
            tx_ready_r    <= tx_nxt;
            rx_ready_r    <= rx_nxt;
        end
    end

    // Clock/reset control registers.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            gen_flag_r    <= 1'b0;
            resume_flag_r <= 1'b0;
            act_flag_r    <= 1'b1;
            ctl_r         <= '0;
        end
        else
        begin
            gen_flag_r    <= gen_nxt;
            resume_flag_r <= resume_nxt;
            act_flag_r    <= act_nxt;
            ctl_r         <= ctl_nxt;
        end
    end

    // Three-stage pin synchronisers; a level counts once stages two and three agree.
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_pin_sync
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    pin_s1_r[gi] <= 1'b0;
                    pin_s2_r[gi] <= 1'b0;
                    pin_s3_r[gi] <= 1'b0;
                    pin_f_r[gi]  <= 1'b0;
                end
                else
                begin
                    pin_s1_r[gi] <= phy_pins[gi];
                    pin_s2_r[gi] <= pin_s1_r[gi];
                    pin_s3_r[gi] <= pin_s2_r[gi];
                    if (pin_s2_r[gi] == pin_s3_r[gi])
                        pin_f_r[gi] <= pin_s3_r[gi];
                end
            end
        end
    endgenerate

    wire uecr_phy_pins_type pin_f = pin_f_r;

    // Without monitoring the PHY ID is taken as high, the idle level of the ID line.
    wire logic phy_id_seen = ctl_r[`UECR_B_PHY_ID_EN] ? pin_f.phy_id : 1'b1;
    assign otg_mon.cable_id    = ctl_r[`UECR_B_ID_OVR_EN] ?
                                 ctl_r[`UECR_B_ID_OVR_VAL] : phy_id_seen;
    assign otg_mon.vbus_valid  = ctl_r[`UECR_B_VBUS_EN] && pin_f.vbus_valid;
    assign otg_mon.a_session   = ctl_r[`UECR_B_ASESS_EN] && pin_f.a_session;
    assign otg_mon.b_session   = ctl_r[`UECR_B_BSESS_EN] && pin_f.b_session;
    assign otg_mon.session_end = ctl_r[`UECR_B_SEND_EN] && pin_f.session_end;

    assign irq_request = (gen_flag_r && ctl_r[`UECR_B_GEN_IE])
                      || (resume_flag_r && ctl_r[`UECR_B_RES_IE])
                      || (act_flag_r && ctl_r[`UECR_B_ACT_IE]);

    // Controls toward the engine.
    assign ep0_ctl.ping_suppress      = host && ping_r;
    assign ep0_ctl.toggle_state       = toggle_r;
    assign ep0_ctl.flush_request      = flush_r;
    assign ep0_ctl.tx_packet_ready    = tx_ready_r;
    assign ep0_ctl.in_request_packet  = in_req_r;
    assign ep0_ctl.status_stage_start = host && stat_req_r && (tx_ready_r || in_req_r);
    assign ep0_ctl.halted             = nak_halt_r;

endmodule : uecr_top

`default_nettype wire

// >>> rtl/uecr_cfg.svh
// Register offsets, bit positions, reset values and bus answers of the endpoint 0 block.
// Assumes inclusion by bare name from the top module.
`ifndef UECR_CFG_SVH
`define UECR_CFG_SVH

`define UECR_ADDR_W          8
`define UECR_OFS_EP0_CSR     8'h00
`define UECR_OFS_CLK_RST     8'h04

`define UECR_EP0_CSR_RESET   32'h0000_0000
`define UECR_CLK_RST_RESET   32'h0100_8000

`define UECR_B_PING_SUPPRESS 27
`define UECR_B_TOGGLE_WREN   26
`define UECR_B_TOGGLE_STATE  25
`define UECR_B_FLUSH         24
`define UECR_B_SVC_SETEND    23
`define UECR_B_SVC_RX        22
`define UECR_B_REQ_PKT       21
`define UECR_B_SETUP_END     20
`define UECR_B_TX_READY      17
`define UECR_B_RX_READY      16

`define UECR_B_GEN_FLAG      26
`define UECR_B_RESUME_FLAG   25
`define UECR_B_ACT_FLAG      24
`define UECR_B_RSVD_ONE      15
`define UECR_B_ID_OVR_EN     9
`define UECR_B_ID_OVR_VAL    8
`define UECR_B_PHY_ID_EN     7
`define UECR_B_VBUS_EN       6
`define UECR_B_ASESS_EN      5
`define UECR_B_BSESS_EN      4
`define UECR_B_SEND_EN       3
`define UECR_B_GEN_IE        2
`define UECR_B_RES_IE        1
`define UECR_B_ACT_IE        0
`define UECR_CTL_W           10

`define UECR_RESP_OKAY       2'h0
`define UECR_RESP_SLVERR     2'h2

`endif

// >>> rtl/uecr_pkg.sv
// Types shared by the endpoint 0 control block and its users.
// Assumes the constants header sits beside this file.
package uecr_pkg;

    // Events and role from the USB engine, same clock domain.
    typedef struct packed {
        logic host_role;
        logic toggle_load;
        logic toggle_value;
        logic rx_packet_in;
        logic tx_sent;
        logic in_done;
        logic setup_end_event;
        logic nak_timeout_event;
        logic flush_done;
    } uecr_ep0_evt_type;

    // Endpoint 0 controls toward the USB engine.
    typedef struct packed {
        logic ping_suppress;
        logic toggle_state;
        logic flush_request;
        logic tx_packet_ready;
        logic in_request_packet;
        logic status_stage_start;
        logic halted;
    } uecr_ep0_ctl_type;

    // Bus-level events from the USB engine, same clock domain.
    typedef struct packed {
        logic bus_event;
        logic bus_event_clear;
        logic suspended;
        logic resume_detect;
        logic activity;
    } uecr_bus_evt_type;

    // Asynchronous indications from the PHY and VBUS comparators.
    typedef struct packed {
        logic phy_id;
        logic vbus_valid;
        logic a_session;
        logic b_session;
        logic session_end;
    } uecr_phy_pins_type;

    // Monitored indications after gating by the enables.
    typedef struct packed {
        logic cable_id;
        logic vbus_valid;
        logic a_session;
        logic b_session;
        logic session_end;
    } uecr_otg_mon_type;

endpackage : uecr_pkg

// >>> testbench/uecr_top_asserts.sv
// Concurrent checks on the endpoint 0 block's ports.
// Assumes the bind below attaches it to the top module.
`timescale 1ns/10ps
`default_nettype none

module uecr_top_asserts
    import uecr_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic              s_axi_rvalid,
    input wire uecr_ep0_evt_type  ep0_evt,
    input wire uecr_ep0_ctl_type  ep0_ctl,
    input wire uecr_phy_pins_type phy_pins,
    input wire uecr_otg_mon_type  otg_mon,
    input wire logic              irq_request
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_ping_role: assert property (ep0_ctl.ping_suppress |-> ep0_evt.host_role)
        else $error("ping outside host role");
    chk_flush_hold: assert property (ep0_ctl.flush_request && !ep0_evt.flush_done
        |=> ep0_ctl.flush_request)
        else $error("flush dropped early");
    chk_flush_clear: assert property (ep0_ctl.flush_request && ep0_evt.flush_done
        && ep0_ctl.tx_packet_ready && !s_axi_wvalid && !$past(s_axi_wvalid)
        |=> !ep0_ctl.flush_request && !ep0_ctl.tx_packet_ready)
        else $error("flush end left flags set");
    chk_nak_halt: assert property (ep0_evt.host_role && ep0_evt.nak_timeout_event
        |=> ep0_ctl.halted)
        else $error("no halt on NAK time-out");
    chk_status_pair: assert property (ep0_ctl.status_stage_start
        |-> ep0_ctl.tx_packet_ready || ep0_ctl.in_request_packet)
        else $error("status stage without packet");
    chk_toggle_hold: assert property (!ep0_evt.toggle_load && !s_axi_wvalid
        && !$past(s_axi_wvalid) |=> $stable(ep0_ctl.toggle_state))
        else $error("toggle changed unasked");
    chk_vbus_sync: assert property ($rose(otg_mon.vbus_valid)
        |-> $past(phy_pins.vbus_valid, 3))
        else $error("VBUS monitor rose early");
    chk_rsvd_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04
        |=> s_axi_rvalid && s_axi_rdata[15] && s_axi_rdata[31:27] == 5'h00
        && s_axi_rdata[23:16] == 8'h00 && s_axi_rdata[14:10] == 5'h00)
        else $error("reserved bits wrong");
    chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid held");

    cov_flush: cover property (ep0_ctl.flush_request && ep0_evt.flush_done);
    cov_status: cover property (ep0_ctl.status_stage_start);
    cov_halt: cover property (ep0_ctl.halted);
    cov_irq: cover property (irq_request);
endmodule : uecr_top_asserts

bind uecr_top uecr_top_asserts #(.ADDR_W(ADDR_W)) u_uecr_top_asserts (
    .clk(clk), .rst(rst), .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .ep0_evt(ep0_evt),
    .ep0_ctl(ep0_ctl), .phy_pins(phy_pins), .otg_mon(otg_mon), .irq_request(irq_request)
);

`default_nettype wire

// >>> testbench/uecr_engine_model.sv
// Model of the USB engine and PHY pins.
// Assumes the bench drives event fields after clock edges.
`timescale 1ns/10ps
`default_nettype none

module uecr_engine_model
    import uecr_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire uecr_ep0_ctl_type ep0_ctl,
    output var uecr_ep0_evt_type  ep0_evt,
    output var uecr_bus_evt_type  bus_evt,
    output var uecr_phy_pins_type phy_pins
);
    int flush_lat;
    int wait_cnt;

    initial
    begin
        ep0_evt = '0;
        bus_evt = '0;
        phy_pins = '0;
        flush_lat = 2;
    end

    // A flush takes flush_lat cycles and ends with one completion pulse.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wait_cnt <= 0;
            ep0_evt.flush_done <= 1'b0;
        end
        else
        begin
            ep0_evt.flush_done <= 1'b0;
            if (wait_cnt > 1)
                wait_cnt <= wait_cnt - 1;
            else if (wait_cnt == 1)
            begin
                wait_cnt <= 0;
                ep0_evt.flush_done <= 1'b1;
            end
            else if (ep0_ctl.flush_request && !ep0_evt.flush_done)
                wait_cnt <= flush_lat;
        end
    end
endmodule : uecr_engine_model

`default_nettype wire

// >>> testbench/usb_ep0_control_and_clkrst_bench.sv
// Self-checking bench of the endpoint 0 block.
// Assumes the engine model and the bound checker.
`timescale 1ns/10ps
`default_nettype none

module usb_ep0_control_and_clkrst_bench;
    import uecr_pkg::*;

    logic              clk;
    logic              rst;
    logic [7:0]        s_axi_awaddr, s_axi_araddr;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0]       s_axi_wdata, s_axi_rdata;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic              s_axi_rvalid, s_axi_rready, irq_request;
    uecr_ep0_evt_type  ep0_evt;
    uecr_ep0_ctl_type  ep0_ctl;
    uecr_bus_evt_type  bus_evt;
    uecr_phy_pins_type phy_pins;
    uecr_otg_mon_type  otg_mon;
    int                n_mismatch = 0;
    int                n_compared = 0;

    uecr_top u_uecr_top (.*);

    uecr_engine_model u_uecr_engine_model (.*);

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
        while (!(aw_ok && w_ok))
        begin
            @(posedge clk);
            aw_ok = aw_ok | s_axi_awready;
            w_ok = w_ok | s_axi_wready;
            s_axi_awvalid <= !aw_ok;
            s_axi_wvalid <= !w_ok;
        end
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        check(s_axi_bresp, resp);
    endtask : wr

    task automatic rd_expect(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        check(s_axi_rresp, (a == 8'h00 || a == 8'h04) ? 32'h0 : 32'h2);
        check(s_axi_rdata & mask, exp);
    endtask : rd_expect

    // Pulses event bits: e for ep0 bits 8:1, b for bus events.
    task automatic pulse(input logic [7:0] e, input logic [4:0] b);
        u_uecr_engine_model.ep0_evt[8:1] <= u_uecr_engine_model.ep0_evt[8:1] | e;
        u_uecr_engine_model.bus_evt <= u_uecr_engine_model.bus_evt | b;
        @(posedge clk);
        u_uecr_engine_model.ep0_evt[8:1] <= u_uecr_engine_model.ep0_evt[8:1] & ~e;
        u_uecr_engine_model.bus_evt <= u_uecr_engine_model.bus_evt & ~b;
        @(posedge clk);
    endtask : pulse

    task automatic set_role(input logic host);
        u_uecr_engine_model.ep0_evt.host_role <= host;
        @(posedge clk);
    endtask : set_role

    function automatic uecr_otg_mon_type exp_mon(input logic [9:0] c, input uecr_phy_pins_type p);
        exp_mon.cable_id = c[9] ? c[8] : (c[7] ? p.phy_id : 1'b1);
        exp_mon.vbus_valid = c[6] & p.vbus_valid;
        exp_mon.a_session = c[5] & p.a_session;
        exp_mon.b_session = c[4] & p.b_session;
        exp_mon.session_end = c[3] & p.session_end;
    endfunction : exp_mon

    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end

    initial
    begin
        logic [9:0] ctl;
        uecr_phy_pins_type pins;
        rst = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'b000;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
        void'($urandom(87));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_expect(8'h04, 32'hFFFF_FFFF, 32'h0100_8000);
        rd_expect(8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
        check(otg_mon, 32'h10);
        wr(8'h08, 32'hFFFF_FFFF, 2'h2);
        rd_expect(8'h08, 32'hFFFF_FFFF, 32'h0000_0000);
        set_role(1'b1);
        wr(8'h00, 32'h0800_0000, 2'h0);
        check(ep0_ctl.ping_suppress, 1);
        set_role(1'b0);
        check(ep0_ctl.ping_suppress, 0);
        set_role(1'b1);
        wr(8'h00, 32'h0600_0000, 2'h0);
        @(posedge clk);
        check(ep0_ctl.toggle_state, 1);
        rd_expect(8'h00, 32'h0600_0000, 32'h0200_0000);
        wr(8'h00, 32'h0000_0000, 2'h0);
        rd_expect(8'h00, 32'h0200_0000, 32'h0200_0000);
        pulse(8'h40, 5'h00);
        check(ep0_ctl.toggle_state, 0);
        pulse(8'h01, 5'h00);
        check(ep0_ctl.halted, 1);
        rd_expect(8'h00, 32'h0080_0000, 32'h0080_0000);
        wr(8'h00, 32'h0000_0000, 2'h0);
        check(ep0_ctl.halted, 0);
        wr(8'h00, 32'h0040_0000, 2'h0);
        check(ep0_ctl.status_stage_start, 0);
        wr(8'h00, 32'h0042_0000, 2'h0);
        check(ep0_ctl.status_stage_start, 1);
        u_uecr_engine_model.flush_lat = 2 + $urandom % 7;
        wr(8'h00, 32'h0100_0000, 2'h0);
        check(ep0_ctl.flush_request, 1);
        repeat (12) @(posedge clk);
        check(ep0_ctl.tx_packet_ready, 0);
        rd_expect(8'h00, 32'h0103_0000, 32'h0000_0000);
        set_role(1'b0);
        pulse(8'h02, 5'h00);
        rd_expect(8'h00, 32'h0010_0000, 32'h0010_0000);
        wr(8'h00, 32'h0080_0000, 2'h0);
        rd_expect(8'h00, 32'h0090_0000, 32'h0000_0000);
        pulse(8'h10, 5'h00);
        rd_expect(8'h00, 32'h0001_0000, 32'h0001_0000);
        wr(8'h00, 32'h0040_0000, 2'h0);
        rd_expect(8'h00, 32'h0041_0000, 32'h0000_0000);
        pulse(8'h10, 5'h00);
        u_uecr_engine_model.flush_lat = 8;
        wr(8'h00, 32'h0100_0000, 2'h0);
        repeat (12) @(posedge clk);
        rd_expect(8'h00, 32'h0101_0000, 32'h0000_0000);
        wr(8'h04, 32'h0000_0007, 2'h0);
        rd_expect(8'h04, 32'hFFFF_FFFF, 32'h0000_8007);
        check(irq_request, 0);
        pulse(8'h00, 5'h10);
        rd_expect(8'h04, 32'h0400_0000, 32'h0400_0000);
        check(irq_request, 1);
        wr(8'h04, 32'h0000_0007, 2'h0);
        rd_expect(8'h04, 32'h0400_0000, 32'h0400_0000);
        pulse(8'h00, 5'h08);
        rd_expect(8'h04, 32'h0400_0000, 32'h0000_0000);
        pulse(8'h00, 5'h02);
        rd_expect(8'h04, 32'h0200_0000, 32'h0000_0000);
        u_uecr_engine_model.bus_evt.suspended <= 1'b1;
        @(posedge clk);
        pulse(8'h00, 5'h02);
        rd_expect(8'h04, 32'h0200_0000, 32'h0200_0000);
        u_uecr_engine_model.bus_evt.suspended <= 1'b0;
        @(posedge clk);
        rd_expect(8'h04, 32'h0200_0000, 32'h0000_0000);
        pulse(8'h00, 5'h01);
        rd_expect(8'h04, 32'h0100_0000, 32'h0100_0000);
        wr(8'h04, 32'h0100_0000, 2'h0);
        check(irq_request, 0);
        wr(8'h04, 32'h0000_0000, 2'h0);
        rd_expect(8'h04, 32'h0100_0000, 32'h0000_0000);
        for (int i = 0; i < 12; i++)
        begin
            ctl = (i == 0) ? 10'h2FF : (i == 1) ? 10'h000 : 10'($urandom);
            pins = 5'($urandom);
            u_uecr_engine_model.phy_pins <= pins;
            repeat (6) @(posedge clk);
            wr(8'h04, {22'h00_4000, ctl}, 2'h0);
            @(posedge clk);
            check(otg_mon, exp_mon(ctl, pins));
            check(irq_request, ctl[0]);
            rd_expect(8'h04, 32'hFFFF_FFFF, {22'h00_4020, ctl});
        end
        wrap_up();
    end
endmodule : usb_ep0_control_and_clkrst_bench

`default_nettype wire
